// file: adc_conversion_control.sv
// converter control: AHB-Lite registers, start scheduling, results
// Summary of operation
// (RL1) two-bit field picks 1.625, 3.25, 6.5 MHz
// (RL2) converter clock divided from internal oscillator
// (RL3) writing one starts channel, zero ignored
// (RL4) capture bit reads one when conversion done
// (RL5) eight 12-bit result registers, one per channel
// (RL6) touch unit enabled: channels 3-0 read zero
// (RL7) conversion lasts 36 to 124 converter clocks
// (RL8) sample time in control bits six to four
// (RL9) resolution bit one: 12-bit, zero: 10-bit
// (RL10) status drops on start, rises on result
`timescale 1ns/100ps
module adc_conversion_control #(
  parameter int CHANNELS = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [11:0] sample_data,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [2:0] conv_channel,
  output logic conv_active,
  output logic irq
);
  import adc_ctl_pkg::*;

  // register state
  logic [7:0] ctrl_r;
  logic [7:0] clock_select_r;
  logic [7:0] capture_r;
  logic [7:0] pending_r;
  logic [7:0] irq_status_r;
  logic [7:0] irq_mask_r;
  logic touch_en_r;
  logic [11:0] result_r [CHANNELS];

  // bus pipeline
  logic wr_pend_r;
  logic [7:0] wr_idx_r;
  logic addr_ok;
  logic [7:0] addr_idx;
  logic rd_req;
  logic wr_req;
  logic [31:0] rd_val;
  logic status_read;

  // decoded write strobes in the data phase
  logic wr_ctrl;
  logic wr_clock_select;
  logic wr_capture;
  logic wr_irq_mask;
  logic wr_touch;
  logic wr_result;
  logic [2:0] wr_result_ch;
  logic [7:0] wr_byte;

  // scheduling
  logic [7:0] start_bits;
  logic pick_valid;
  logic [2:0] pick_ch;
  conv_req_t req;
  conv_res_t res;
  logic engine_busy;
  logic conv_tick;
  logic [7:0] done_bits;

  // address phase; only whole-word accesses are expected
  assign addr_ok = (haddr[1:0] == 2'b00) && (haddr[31:10] == 22'h0);
  assign addr_idx = haddr[9:2];
  assign rd_req = hsel && hready && htrans[1] && !hwrite;
  assign wr_req = hsel && hready && htrans[1] && hwrite && addr_ok;

  // unused in a zero-wait, word-only slave
  logic unused_hsize;
  assign unused_hsize = ^hsize;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_idx_r <= 8'h00;
    end else begin
      wr_pend_r <= wr_req;
      if (wr_req) begin
        wr_idx_r <= addr_idx;
      end
    end
  end

  // every access completes with no wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  assign wr_byte = hwdata[7:0];
  assign wr_ctrl = wr_pend_r && (wr_idx_r == IDX_CTRL);
  assign wr_clock_select = wr_pend_r && (wr_idx_r == IDX_CLOCK_SELECT);
  assign wr_capture = wr_pend_r && (wr_idx_r == IDX_CAPTURE);
  assign wr_irq_mask = wr_pend_r && (wr_idx_r == IDX_IRQ_MASK);
  assign wr_touch = wr_pend_r && (wr_idx_r == IDX_TOUCH_CTRL);
  assign wr_result = wr_pend_r && (wr_idx_r[7:4] == IDX_RESULT_BASE[7:4])
                     && !wr_idx_r[0];
  assign wr_result_ch = wr_idx_r[3:1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= RST_CTRL;
    end else if (wr_ctrl) begin
      ctrl_r <= (wr_byte & CTRL_WMASK) | (ctrl_r & ~CTRL_WMASK); // (RL8)
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clock_select_r <= RST_CLOCK_SELECT;
    end else if (wr_clock_select) begin
      clock_select_r <= wr_byte & CLOCK_SELECT_WMASK; // (RL1)
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask_r <= RST_IRQ_MASK;
    end else if (wr_irq_mask) begin
      irq_mask_r <= wr_byte;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      touch_en_r <= 1'b0;
    end else if (wr_touch) begin
      touch_en_r <= wr_byte[TOUCH_EN_BIT];
    end
  end

  // start requests: written ones only
  assign start_bits = wr_capture ? wr_byte : 8'h00; // (RL3)

  // lowest pending channel goes first when the timer is free
  always_comb begin
    pick_valid = 1'b0;
    pick_ch = 3'h0;
    for (int i = CHANNELS - 1; i >= 0; i--) begin
      if (pending_r[i]) begin
        pick_valid = 1'b1;
        pick_ch = 3'(i);
      end
    end
  end

  assign req.start = pick_valid && !engine_busy;
  assign req.channel = pick_ch;

  // a restart of a queued channel just stays queued
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pending_r <= 8'h00;
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (start_bits[i]) begin
          pending_r[i] <= 1'b1; // (RL3)
        end else if (req.start && pick_ch == 3'(i)) begin
          pending_r[i] <= 1'b0;
        end
      end
    end
  end

  assign done_bits = res.done ? (8'h01 << res.channel) : 8'h00;

  // a restart written in the finishing cycle keeps the bit low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      capture_r <= RST_CAPTURE;
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (start_bits[i]) begin
          capture_r[i] <= 1'b0; // (RL10)
        end else if (done_bits[i]) begin
          capture_r[i] <= 1'b1; // (RL10)
        end
      end
    end
  end

  // result store; software may also overwrite a result
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < CHANNELS; i++) begin
        result_r[i] <= RST_RESULT;
      end
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (done_bits[i]) begin
          result_r[i] <= res.data; // (RL5)
        end else if (wr_result && wr_result_ch == 3'(i)) begin
          result_r[i] <= hwdata[11:0];
        end
      end
    end
  end

  // completion events; a new event beats the read clear
  assign status_read = rd_req && addr_ok && (addr_idx == IDX_IRQ_STATUS);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status_r <= 8'h00;
    end else if (status_read) begin
      irq_status_r <= done_bits;
    end else begin
      irq_status_r <= irq_status_r | done_bits;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((irq_status_r & ~(status_read ? irq_status_r : 8'h00))
               | done_bits) & irq_mask_r);
    end
  end

  // read mux, sampled in the address phase
  always_comb begin
    rd_val = 32'h0000_0000;
    if (addr_ok) begin
      if (addr_idx == IDX_CTRL) begin
        rd_val = {24'h0, ctrl_r}; // (RL8)
      end else if (addr_idx == IDX_CLOCK_SELECT) begin
        rd_val = {24'h0, clock_select_r};
      end else if (addr_idx == IDX_CAPTURE) begin
        rd_val = {24'h0, capture_r}; // (RL4)
      end else if (addr_idx == IDX_IRQ_STATUS) begin
        rd_val = {24'h0, irq_status_r};
      end else if (addr_idx == IDX_IRQ_MASK) begin
        rd_val = {24'h0, irq_mask_r};
      end else if (addr_idx == IDX_TOUCH_CTRL) begin
        rd_val = {31'h0, touch_en_r};
      end else if (addr_idx[7:4] == IDX_RESULT_BASE[7:4]
                   && !addr_idx[0]) begin
        if (touch_en_r && addr_idx[3:1] < 3'(TOUCH_CHANNELS)) begin
          rd_val = 32'h0000_0000; // (RL6)
        end else begin
          rd_val = {20'h0, result_r[addr_idx[3:1]]}; // (RL5)
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_req) begin
      hrdata <= rd_val;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv_channel <= 3'h0;
    end else if (req.start) begin
      conv_channel <= req.channel;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv_active <= 1'b0;
    end else begin
      conv_active <= req.start || (engine_busy && !res.done);
    end
  end

  adc_clock_gen u_clock_gen (
    .hclk(hclk),
    .hresetn(hresetn),
    .freq_sel(clock_select_r[FREQ_MSB:FREQ_LSB]), // (RL1)
    .conv_tick(conv_tick)
  );

  adc_conv_engine u_engine (
    .hclk(hclk),
    .hresetn(hresetn),
    .conv_tick(conv_tick),
    .req(req),
    .length(conv_length(ctrl_r[SAMPLE_TIME_MSB:SAMPLE_TIME_LSB])), // (RL7)
    .resolution_select(ctrl_r[RESOLUTION_BIT]), // (RL9)
    .sample_data(sample_data),
    .busy(engine_busy),
    .res(res)
  );
endmodule

// file: adc_ctl_pkg.sv
// shared constants and types for the converter control block
package adc_ctl_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTRL = 8'h20;
  localparam logic [7:0] IDX_CLOCK_SELECT = 8'h21;
  localparam logic [7:0] IDX_CAPTURE = 8'h22;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h24;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h25;
  localparam logic [7:0] IDX_RESULT_BASE = 8'h30;
  localparam logic [7:0] IDX_TOUCH_CTRL = 8'h40;

  // reset values
  localparam logic [7:0] RST_CTRL = 8'h1C;
  localparam logic [7:0] RST_CLOCK_SELECT = 8'h01;
  localparam logic [7:0] RST_CAPTURE = 8'hFF;
  localparam logic [11:0] RST_RESULT = 12'h000;
  localparam logic [7:0] RST_IRQ_MASK = 8'h00;

  // field positions
  localparam int SAMPLE_TIME_LSB = 4;
  localparam int SAMPLE_TIME_MSB = 6;
  localparam int RESOLUTION_BIT = 3;
  localparam int FREQ_LSB = 0;
  localparam int FREQ_MSB = 1;
  localparam int TOUCH_EN_BIT = 0;
  localparam int TOUCH_CHANNELS = 4;

  // writable bit masks
  localparam logic [7:0] CTRL_WMASK = 8'h7A;
  localparam logic [7:0] CLOCK_SELECT_WMASK = 8'h03;

  // oscillator and bus clock, in kHz
  localparam int HCLK_KHZ = 40000;
  localparam int OSC_KHZ = 6500;

  // converter clock divide by code: 00 /4, 01 /2, 1x /1
  localparam logic [1:0] FREQ_DIV4 = 2'h0;
  localparam logic [1:0] FREQ_DIV2 = 2'h1;

  typedef struct packed {
    logic       start;
    logic [2:0] channel;
  } conv_req_t;

  typedef struct packed {
    logic        done;
    logic [2:0]  channel;
    logic [11:0] data;
  } conv_res_t;

  // conversion length in converter clocks for each sample-time code
  function automatic logic [7:0] conv_length(input logic [2:0] code);
    logic [7:0] len;
    len = 8'h7C;
    unique case (code)
      3'h0: len = 8'h24;
      3'h1: len = 8'h2C;
      3'h2: len = 8'h38;
      3'h3: len = 8'h40;
      3'h4: len = 8'h50;
      3'h5: len = 8'h60;
      3'h6: len = 8'h7C;
      3'h7: len = 8'h7C;
    endcase
    return len;
  endfunction

endpackage

// file: adc_clock_gen.sv
// internal oscillator model and converter clock divider
`timescale 1ns/100ps
module adc_clock_gen (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [1:0] freq_sel,
  output logic conv_tick
);
  import adc_ctl_pkg::*;

  localparam logic [15:0] ACC_STEP = 16'(OSC_KHZ);
  localparam logic [15:0] ACC_MOD = 16'(HCLK_KHZ);

  logic [15:0] acc_r;
  logic [15:0] acc_sum;
  logic osc_tick;
  logic [1:0] div_r;
  logic div_hit;

  assign acc_sum = acc_r + ACC_STEP;
  assign osc_tick = (acc_sum >= ACC_MOD);

  // fractional accumulator: free-running oscillator ticks, no pin input
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_r <= 16'h0000;
    end else if (osc_tick) begin
      acc_r <= acc_sum - ACC_MOD; // (RL2)
    end else begin
      acc_r <= acc_sum;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_r <= 2'h0;
    end else if (osc_tick) begin
      div_r <= div_r + 2'h1;
    end
  end

  always_comb begin
    unique case (freq_sel)
      FREQ_DIV4: div_hit = (div_r == 2'h3); // (RL1)
      FREQ_DIV2: div_hit = div_r[0]; // (RL1)
      default: div_hit = 1'b1; // (RL1)
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv_tick <= 1'b0;
    end else begin
      conv_tick <= osc_tick && div_hit; // (RL2)
    end
  end
endmodule

// file: adc_conv_engine.sv
// conversion timer: counts converter clocks and captures the sample
`timescale 1ns/100ps
module adc_conv_engine (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic conv_tick,
  input wire adc_ctl_pkg::conv_req_t req,
  input wire logic [7:0] length,
  input wire logic resolution_select,
  input wire logic [11:0] sample_data,
  output logic busy,
  output adc_ctl_pkg::conv_res_t res
);
  import adc_ctl_pkg::*;

  logic [2:0] chan_r;
  logic [7:0] count_r;
  logic [7:0] len_r;
  logic finish;

  assign finish = busy && conv_tick && (count_r == len_r - 8'h01);

  // length is latched at start so a mid-conversion change is harmless
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy <= 1'b0;
      chan_r <= 3'h0;
      len_r <= 8'h24;
    end else if (!busy && req.start) begin
      busy <= 1'b1;
      chan_r <= req.channel;
      len_r <= length; // (RL7)
    end else if (finish) begin
      busy <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_r <= 8'h00;
    end else if (!busy) begin
      count_r <= 8'h00;
    end else if (conv_tick) begin
      count_r <= count_r + 8'h01; // (RL7)
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      res <= '0;
    end else begin
      res.done <= finish;
      res.channel <= chan_r;
      if (finish) begin
        res.data <= resolution_select ? sample_data
                    : {sample_data[11:2], 2'b00}; // (RL9)
      end
    end
  end
endmodule

// file: adc_ctl_properties.sv
// concurrent checks on the converter control block ports
`timescale 1ns/100ps
module adc_ctl_properties #(
  parameter int CHANNELS = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [11:0] sample_data,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [2:0] conv_channel,
  input wire logic conv_active,
  input wire logic irq
);
  logic taken;
  logic wpend_r;
  logic touch_r;
  logic [31:0] waddr_r;
  logic [7:0] mask_r;
  logic [11:0] run_r;
  assign taken = hsel && hready && htrans[1];
  // shadow of the written mask and touch enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wpend_r <= 1'b0;
      waddr_r <= 32'h0;
    end else begin
      wpend_r <= taken && hwrite;
      waddr_r <= haddr;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      touch_r <= 1'b0;
      mask_r <= 8'h00;
    end else if (wpend_r) begin
      if (waddr_r == 32'h100) begin
        touch_r <= hwdata[0];
      end
      if (waddr_r == 32'h94) begin
        mask_r <= hwdata[7:0];
      end
    end
  end
  // run length; too long for a repetition
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_r <= 12'h000;
    end else begin
      run_r <= conv_active ? run_r + 12'h001 : 12'h000;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence cap_wr;
    taken && hwrite && haddr == 32'h88
      ##1 hwdata[7:0] != 8'h00 && !conv_active;
  endsequence
  sequence rd_of(logic [31:0] a);
    taken && !hwrite && haddr == a;
  endsequence
  chk_ready_high: assert property (hreadyout == 1'b1)
    else $error("hreadyout low");
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("hresp not okay");
  chk_start_conv: assert property (cap_wr |-> ##[1:4] conv_active)
    else $error("capture write did not start a conversion");
  chk_conv_length: assert property ($fell(conv_active) |->
    run_r >= 12'h0B4 && run_r <= 12'hDAC)
    else $error("conversion length out of range");
  chk_busy_reads: assert property (rd_of(32'h88) ##0 conv_active
    |=> hrdata[$past(conv_channel)] == 1'b0)
    else $error("busy channel read as done");
  chk_result_width: assert property (taken && !hwrite &&
    haddr >= 32'hC0 && haddr <= 32'hF8 |=> hrdata[31:12] == 20'h0)
    else $error("result wider than 12 bits");
  chk_touch_zero: assert property (taken && !hwrite && touch_r &&
    haddr[31:5] == 27'h6 |=> hrdata == 32'h0)
    else $error("touch channel result not zero");
  chk_freq_field: assert property (rd_of(32'h84)
    |=> hrdata[31:2] == 30'h0)
    else $error("clock select reserved bits set");
  chk_irq_masked: assert property (irq |-> $past(mask_r) != 8'h00)
    else $error("irq with all sources masked");
endmodule
bind adc_conversion_control adc_ctl_properties #(.CHANNELS(CHANNELS)) chk_u (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
  .hready, .sample_data, .hrdata, .hreadyout, .hresp, .conv_channel,
  .conv_active, .irq);

// file: adc_conversion_control_bench.sv
// self-checking bench for the converter control block
`timescale 1ns/100ps
module adc_conversion_control_bench;
  import adc_ctl_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [11:0] sample_data = 12'h000;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic irq;
  logic conv_active;
  logic [2:0] conv_channel;
  logic [31:0] r;
  int fail_count = 0;
  int samples_checked = 0;
  int c;
  always #12.5 hclk = ~hclk;
  adc_conversion_control dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .sample_data, .hrdata,
    .hreadyout, .hresp, .conv_channel, .conv_active, .irq);
  task automatic results;
    if (fail_count == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one whole-word transfer; waits on hready, no fixed latency assumed
  task automatic xfer(input logic w, input logic [31:0] a, d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, d);
    xfer(1'b1, a, d);
  endtask
  task automatic rdc(input logic [31:0] a, exp, input string what);
    xfer(1'b0, a, 32'h0);
    chk(r, exp, what);
  endtask
  // cycles to irq against len ticks of a 6.5 MHz tick divided by k
  task automatic conv(input int k, len);
    c = 0;
    while (irq !== 1'b1 && c < 5000) begin
      @(posedge hclk);
      c++;
    end
    chk(c >= len * k * 6 - 10 && c <= (len + 1) * k * 7 + 10, 1, "time");
  endtask
  initial begin
    repeat (20000) @(posedge hclk);
    fail_count++;
    results;
  end
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(32'h80, 32'h1C, "ctrl");
    rdc(32'h84, 32'h01, "clk_sel");
    rdc(32'h88, 32'hFF, "capture");
    rdc(32'hC0, 32'h0, "result0");
    rdc(32'h0C, 32'h0, "unmapped");
    wr(32'h84, 32'hFF);
    rdc(32'h84, 32'h03, "clk_sel");
    wr(32'h94, 32'hFF);
    wr(32'h80, 32'h08);
    // reserved bit 2 is not writable and keeps its reset one
    rdc(32'h80, 32'h0C, "ctrl");
    // every divider code, 36 ticks each
    for (int f = 0; f < 4; f++) begin
      wr(32'h84, 32'(f));
      sample_data <= 12'hA50 + 12'(f);
      wr(32'h88, 32'h1 << f);
      rdc(32'h88, 32'hFF ^ (32'h1 << f), "capture");
      chk({29'h0, conv_channel}, 32'(f), "channel");
      chk({31'h0, conv_active}, 32'h1, "active");
      rdc(32'h88, 32'hFF ^ (32'h1 << f), "capture");
      conv(f == 0 ? 4 : (f == 1 ? 2 : 1), 36);
      rdc(32'h88, 32'hFF, "capture");
      chk({31'h0, conv_active}, 32'h0, "active");
      rdc(32'hC0 + 32'(8 * f), 32'hA50 + 32'(f), "result");
      rdc(32'h90, 32'h1 << f, "status");
      rdc(32'h90, 32'h0, "status");
      chk({31'h0, irq}, 32'h0, "irq");
    end
    // longest sample time in 10-bit mode
    wr(32'h80, 32'h60);
    sample_data <= 12'h7FF;
    wr(32'h88, 32'h80);
    conv(1, 124);
    rdc(32'hF8, 32'h7FC, "result7");
    rdc(32'h90, 32'h80, "status");
    // two channels in one write run one after the other
    wr(32'h80, 32'h08);
    sample_data <= 12'h123;
    wr(32'h88, 32'h30);
    conv(1, 36);
    rdc(32'h90, 32'h10, "status");
    conv(1, 36);
    rdc(32'h90, 32'h20, "status");
    rdc(32'hE0, 32'h123, "result4");
    rdc(32'hE8, 32'h123, "result5");
    rdc(32'hC0, 32'hA50, "result0");
    // masked event: status still sets, interrupt stays low
    wr(32'h94, 32'h00);
    wr(32'h88, 32'h40);
    repeat (300) @(posedge hclk);
    chk({31'h0, irq}, 32'h0, "irq_masked");
    rdc(32'h88, 32'hFF, "capture6");
    rdc(32'hF0, 32'h123, "result6");
    rdc(32'h90, 32'h40, "status");
    wr(32'h94, 32'hFF);
    wr(32'h100, 32'h1);
    rdc(32'hC0, 32'h0, "result0");
    rdc(32'hD8, 32'h0, "result3");
    rdc(32'hE0, 32'h123, "result4");
    wr(32'h100, 32'h0);
    rdc(32'hD8, 32'hA53, "result3");
    results;
  end
endmodule
